/* hw/ptm_consts.svh */
// Purpose: constants for the 10-bit periodic timer
// Assumes: AHB-Lite word registers, byte offsets below
// Notes:   one register per aligned word, data in the low bits
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH

`define PTM_CW            10
`define PTM_CNT_MAX       10'h3FF
`define PTM_CNT_ZERO      10'h000

`define PTM_OFF_CTRL0     8'h00
`define PTM_OFF_CTRL1     8'h04
`define PTM_OFF_CNTL      8'h08
`define PTM_OFF_CNTH      8'h0C
`define PTM_OFF_CMPL      8'h10
`define PTM_OFF_CMPH      8'h14
`define PTM_OFF_PERL      8'h18
`define PTM_OFF_PERH      8'h1C
`define PTM_OFF_FLAGS     8'h20

// control 0 fields
`define PTM_C0_PAUSE      7
`define PTM_C0_CKS_HI     6
`define PTM_C0_CKS_LO     4
`define PTM_C0_ON         3
// control 1 fields
`define PTM_C1_MODE_HI    7
`define PTM_C1_MODE_LO    6
`define PTM_C1_PIN_HI     5
`define PTM_C1_PIN_LO     4
`define PTM_C1_OLS        3
`define PTM_C1_INV        2
`define PTM_C1_CAPS       1
`define PTM_C1_CLR        0
// flag register fields, write one to clear
`define PTM_FL_MA         0
`define PTM_FL_MP         1

`define PTM_PIN_NONE      2'h0
`define PTM_PIN_LOW       2'h1
`define PTM_PIN_HIGH      2'h2
`define PTM_PIN_TOGGLE    2'h3
`define PTM_PIN_INACT     2'h0
`define PTM_PIN_ACT       2'h1
`define PTM_PIN_PWM       2'h2

`define PTM_DIV4_LAST     2'h3
`define PTM_DIV16_LAST    4'hF
`define PTM_DIV64_LAST    6'h3F

`define PTM_HTRANS_NONSEQ 2'h2
`define PTM_HSIZE_WORD    3'h2
`define PTM_ADDR_LSB      2
`define PTM_ADDR_MSB      7

`endif

/* hw/ptm_pkg.sv */
// Purpose: types for the 10-bit periodic timer
// Assumes: nothing
// Notes:   mode codes follow the two-bit mode select field
package ptm_pkg;
    typedef enum logic [1:0] {
        PTM_MODE_COMPARE = 2'h0,
        PTM_MODE_CAPTURE = 2'h1,
        PTM_MODE_PWM     = 2'h2,
        PTM_MODE_TIMER   = 2'h3
    } ptm_mode_type;
    typedef logic [9:0] ptm_count_type;
endpackage

/* hw/ptm_timer.sv */
// Purpose: 10-bit periodic timer with compare A and period P, AHB-Lite slave
// Assumes: pins synchronous to ref_clk; slave answers with zero wait states
// Notes:   the single pulse and capture paths are kept minimal
// Operation
// - compare mode: level select sets initial pin
// - pwm mode: level select picks active polarity
// - single pulse: level select sets start level
// - level and invert ignored in timer mode
// - invert bit inverts the output pin
// - capture source: capture pin or clock pin
// - clear on A match, else P/overflow
// - overflow clear only when period is zero
// - clear select ignored outside compare/timer modes
// - counter readable as low and high byte
// - compare and period are 10-bit read/write
// - mode 00 is compare match output
// - clear select 0 raises both flags
// - clear select 1 raises only A flag
// - compare zero: overflow at 3FF, no A flag
// - only comparator A moves the pin
// - A match drives high, low or toggles
// - counter on rising resets pin to initial
// - mode 11 counts like compare, pin unused
// - pwm: period sets frequency, compare sets duty
// - pwm raises both match flags, single pulse only the A flag
// - pin action enables pwm or forces level
// - on rising clears count, falling holds it
// - compare codes: none, low, high, toggle
// - pwm codes: inactive, active, pwm, single
// - duty at or over period stays active
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`include "ptm_consts.svh"

module ptm_timer (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  capturePin,
    input  wire logic                  extClockPin,
    input  wire logic                  fastTickIn,
    input  wire logic                  subTickIn,
    output logic                       timerOut,
    output logic                       timerOutEn,
    output logic                       matchA,
    output logic                       matchP,
    output ptm_pkg::ptm_count_type     captureValue
);
    import ptm_pkg::*;

    logic [7:0]    ctrl0_q;
    logic [7:0]    ctrl1_q;
    ptm_count_type count_q;
    ptm_count_type compare_q;
    ptm_count_type period_q;
    logic          flagA_q;
    logic          flagP_q;
    logic          onPrev_q;
    logic          pinLevel_q;
    logic          pulseOn_q;
    logic          extPrev_q;
    logic          capPrev_q;
    logic [1:0]    div4_q;
    logic [3:0]    div16_q;
    logic [5:0]    div64_q;
    logic          wrPend_q;
    logic [7:0]    wrAddr_q;
    logic          onRise;
    logic          perHit;
    ptm_mode_type mode;
    logic [1:0]   pinSel;
    logic         tick;
    logic         running;
    logic         hitA;
    logic         hitP;
    logic         clearCnt;
    logic         rawA;
    logic         rawP;
    logic         capSrc;
    logic         capEdge;
    logic         pwmActive;
    logic         pulseMode;
    logic         wrStrobe;
    logic         rdAccept;
    logic         busAccept;
    function automatic logic sel_bit(input logic [7:0] r, input int unsigned pos);
        sel_bit = r[pos];
    endfunction
    function automatic logic [31:0] low_byte(input ptm_count_type v);
        low_byte = {24'h000000, v[7:0]};
    endfunction
    function automatic logic [31:0] high_bits(input ptm_count_type v);
        high_bits = {30'h0, v[9:8]};
    endfunction
    assign mode      = ptm_mode_type'(ctrl1_q[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO]);
    assign pinSel    = ctrl1_q[`PTM_C1_PIN_HI:`PTM_C1_PIN_LO];
    assign onRise    = sel_bit(ctrl0_q, `PTM_C0_ON) && !onPrev_q;
    assign pulseMode = (mode == PTM_MODE_PWM) && (pinSel == `PTM_PIN_TOGGLE);
    assign running   = sel_bit(ctrl0_q, `PTM_C0_ON) && !sel_bit(ctrl0_q, `PTM_C0_PAUSE)
                       && !onRise;
    // counter clock divider: one-cycle enables only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div4_q  <= 2'h0;
            div16_q <= 4'h0;
            div64_q <= 6'h00;
        end else begin
            div4_q  <= div4_q + 2'h1;
            div16_q <= fastTickIn ? div16_q + 4'h1 : div16_q;
            div64_q <= fastTickIn ? div64_q + 6'h01 : div64_q;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            extPrev_q <= 1'b0;
            capPrev_q <= 1'b0;
        end else begin
            extPrev_q <= extClockPin;
            capPrev_q <= capSrc;
        end
    end
    always_comb begin
        unique case (ctrl0_q[`PTM_C0_CKS_HI:`PTM_C0_CKS_LO])
            3'h0:    tick = (div4_q == `PTM_DIV4_LAST);
            3'h1:    tick = 1'b1;
            3'h2:    tick = fastTickIn && (div16_q == `PTM_DIV16_LAST);
            3'h3:    tick = fastTickIn && (div64_q == `PTM_DIV64_LAST);
            3'h4:    tick = subTickIn;
            3'h5:    tick = subTickIn;
            3'h6:    tick = extClockPin && !extPrev_q;
            default: tick = !extClockPin && extPrev_q;
        endcase
    end
    // comparators see the count as it stands when the tick lands
    assign hitA   = running && tick && (count_q == compare_q);
    assign hitP   = running && tick && (count_q == period_q);
    // period zero never clears: the count runs to 3FF and wraps
    assign perHit = hitP && (period_q != `PTM_CNT_ZERO);
    always_comb begin
        clearCnt = 1'b0;
        rawA     = 1'b0;
        rawP     = 1'b0;
        unique case (mode)
            PTM_MODE_COMPARE, PTM_MODE_TIMER: begin
                if (sel_bit(ctrl1_q, `PTM_C1_CLR)) begin
                    // a zero compare never clears, so the count still wraps
                    clearCnt = hitA && (compare_q != `PTM_CNT_ZERO);
                    rawA     = hitA && (compare_q != `PTM_CNT_ZERO);
                end else begin
                    clearCnt = perHit;
                    rawA     = hitA && (compare_q != `PTM_CNT_ZERO);
                    rawP     = perHit;
                end
            end
            PTM_MODE_PWM: begin
                // clear select ignored here
                clearCnt = !pulseMode && perHit;
                rawA     = hitA;
                rawP     = !pulseMode && perHit;
            end
            PTM_MODE_CAPTURE: begin
                clearCnt = perHit;
                rawP     = perHit;
            end
        endcase
    end
    assign capSrc  = sel_bit(ctrl1_q, `PTM_C1_CAPS) ? extClockPin : capturePin;
    always_comb begin
        unique case (pinSel)
            2'h0:    capEdge = capSrc && !capPrev_q;
            2'h1:    capEdge = !capSrc && capPrev_q;
            2'h2:    capEdge = capSrc != capPrev_q;
            default: capEdge = 1'b0;
        endcase
    end
    // counter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q  <= `PTM_CNT_ZERO;
            onPrev_q <= 1'b0;
        end else begin
            onPrev_q <= sel_bit(ctrl0_q, `PTM_C0_ON);
            if (onRise) begin
                count_q <= `PTM_CNT_ZERO;
            end else if (running && tick && !(pulseMode && !pulseOn_q)) begin
                // wrap from 3FF falls out of the 10-bit add
                count_q <= clearCnt ? `PTM_CNT_ZERO : count_q + 10'h001;
            end
        end
    end
    // pwm level before polarity: active while count below compare
    assign pwmActive = (count_q < compare_q) || (compare_q >= period_q
                       && period_q != `PTM_CNT_ZERO);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinLevel_q <= 1'b0;
            pulseOn_q  <= 1'b0;
        end else if (onRise) begin
            pinLevel_q <= sel_bit(ctrl1_q, `PTM_C1_OLS);
            pulseOn_q  <= 1'b1;
        end else if (mode == PTM_MODE_COMPARE) begin
            if (rawA) begin
                unique case (pinSel)
                    `PTM_PIN_NONE:   pinLevel_q <= pinLevel_q;
                    `PTM_PIN_LOW:    pinLevel_q <= 1'b0;
                    `PTM_PIN_HIGH:   pinLevel_q <= 1'b1;
                    `PTM_PIN_TOGGLE: pinLevel_q <= !pinLevel_q;
                endcase
            end
        end else if (pulseMode) begin
            if (hitA || !sel_bit(ctrl0_q, `PTM_C0_ON)) begin
                pulseOn_q <= 1'b0;
            end
        end
    end

    // output pin, registered; timer mode leaves the pin undriven
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            timerOut   <= 1'b0;
            timerOutEn <= 1'b0;
        end else begin
            timerOutEn <= (mode != PTM_MODE_TIMER) && (mode != PTM_MODE_CAPTURE);
            unique case (mode)
                PTM_MODE_COMPARE:
                    timerOut <= pinLevel_q ^ sel_bit(ctrl1_q, `PTM_C1_INV);
                PTM_MODE_PWM: begin
                    unique case (pinSel)
                        `PTM_PIN_INACT: timerOut <= !sel_bit(ctrl1_q, `PTM_C1_OLS)
                                                    ^ sel_bit(ctrl1_q, `PTM_C1_INV);
                        `PTM_PIN_ACT:   timerOut <= sel_bit(ctrl1_q, `PTM_C1_OLS)
                                                    ^ sel_bit(ctrl1_q, `PTM_C1_INV);
                        `PTM_PIN_PWM:   timerOut <= !(pwmActive ^ sel_bit(ctrl1_q,
                                                    `PTM_C1_OLS)) ^ sel_bit(ctrl1_q,
                                                    `PTM_C1_INV);
                        default:        timerOut <= !(pulseOn_q ^ sel_bit(ctrl1_q,
                                                    `PTM_C1_OLS)) ^ sel_bit(ctrl1_q,
                                                    `PTM_C1_INV);
                    endcase
                end
                default: timerOut <= 1'b0;
            endcase
        end
    end

    // AHB-Lite: zero wait states, writes land one cycle after the address phase
    assign busAccept = hsel && hready && (htrans == `PTM_HTRANS_NONSEQ);
    assign rdAccept  = busAccept && !hwrite;
    assign wrStrobe  = wrPend_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_q  <= 1'b0;
            wrAddr_q  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= busAccept && hwrite && (hsize == `PTM_HSIZE_WORD);
            if (busAccept) begin
                wrAddr_q <= haddr[`PTM_ADDR_MSB:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0_q   <= 8'h00;
            ctrl1_q   <= 8'h00;
            compare_q <= `PTM_CNT_ZERO;
            period_q  <= `PTM_CNT_ZERO;
        end else begin
            if (wrStrobe) begin
                unique case (wrAddr_q)
                    `PTM_OFF_CTRL0: ctrl0_q <= {hwdata[7:3], 3'h0};
                    `PTM_OFF_CTRL1: ctrl1_q <= hwdata[7:0];
                    `PTM_OFF_CMPL:  compare_q[7:0] <= hwdata[7:0];
                    `PTM_OFF_CMPH:  compare_q[9:8] <= hwdata[1:0];
                    `PTM_OFF_PERL:  period_q[7:0] <= hwdata[7:0];
                    `PTM_OFF_PERH:  period_q[9:8] <= hwdata[1:0];
                    default: ;
                endcase
            end
            if (pulseMode && hitA) begin
                ctrl0_q[`PTM_C0_ON] <= 1'b0;
            end else if (pulseMode && tick && ctrl0_q[6:5] == 2'h3) begin
                ctrl0_q[`PTM_C0_ON] <= 1'b1;
            end
            if (mode == PTM_MODE_CAPTURE && capEdge && sel_bit(ctrl0_q, `PTM_C0_ON)) begin
                compare_q <= count_q;
            end
        end
    end
    // sticky flags: a new match wins over the write-one clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flagA_q <= 1'b0;
            flagP_q <= 1'b0;
        end else begin
            flagA_q <= rawA || (flagA_q && !(wrStrobe && wrAddr_q == `PTM_OFF_FLAGS
                       && hwdata[`PTM_FL_MA]));
            flagP_q <= rawP || (flagP_q && !(wrStrobe && wrAddr_q == `PTM_OFF_FLAGS
                       && hwdata[`PTM_FL_MP]));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            matchA       <= 1'b0;
            matchP       <= 1'b0;
            captureValue <= `PTM_CNT_ZERO;
            hrdata       <= 32'h00000000;
        end else begin
            matchA       <= rawA;
            matchP       <= rawP;
            captureValue <= compare_q;
            if (rdAccept) begin
                unique case (haddr[`PTM_ADDR_MSB:0])
                    `PTM_OFF_CTRL0: hrdata <= {24'h000000, ctrl0_q};
                    `PTM_OFF_CTRL1: hrdata <= {24'h000000, ctrl1_q};
                    `PTM_OFF_CNTL:  hrdata <= low_byte(count_q);
                    `PTM_OFF_CNTH:  hrdata <= high_bits(count_q);
                    `PTM_OFF_CMPL:  hrdata <= low_byte(compare_q);
                    `PTM_OFF_CMPH:  hrdata <= high_bits(compare_q);
                    `PTM_OFF_PERL:  hrdata <= low_byte(period_q);
                    `PTM_OFF_PERH:  hrdata <= high_bits(period_q);
                    `PTM_OFF_FLAGS: hrdata <= {30'h0, flagP_q, flagA_q};
                    default:        hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    a_clear_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (mode == PTM_MODE_COMPARE && ctrl1_q[`PTM_C1_CLR] && rawA && !onRise)
        |=> count_q == `PTM_CNT_ZERO)
        else $error("count not cleared on compare A match");
    a_no_p_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (mode == PTM_MODE_COMPARE && ctrl1_q[`PTM_C1_CLR]) |-> !rawP)
        else $error("match P flagged with clear on A");
    a_zero_cmp: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (mode == PTM_MODE_COMPARE && compare_q == `PTM_CNT_ZERO) |-> !rawA)
        else $error("match A flagged with zero compare");
    a_on_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
        onRise |=> count_q == `PTM_CNT_ZERO)
        else $error("count not zero after enable");
    a_pin_init: assert property (@(posedge ref_clk) disable iff (!rst_b)
        onRise |=> pinLevel_q == $past(ctrl1_q[`PTM_C1_OLS]))
        else $error("pin not at initial level");
    a_toggle_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (mode == PTM_MODE_COMPARE && rawA && pinSel == `PTM_PIN_TOGGLE && !onRise)
        |=> pinLevel_q != $past(pinLevel_q))
        else $error("pin did not toggle");
    a_hold_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!ctrl0_q[`PTM_C0_ON] && !onRise) |=> $stable(count_q))
        else $error("count moved while off");
    a_timer_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (mode == PTM_MODE_TIMER) ##1 (mode == PTM_MODE_TIMER) |-> !timerOutEn)
        else $error("pin driven in timer mode");
endmodule

/* tb/tb_periodic_timer_10bit.sv */
// Purpose: self-checking bench for the 10-bit periodic timer
// Assumes: counter ticks come from subTickIn with clock select 4
// Notes:   bench drives ticks itself so the model needs no cycle-exact pipeline
`include "ptm_consts.svh"
module tb_periodic_timer_10bit;
    timeunit 1ns;
    timeprecision 1ns;
    import ptm_pkg::*;
    logic          ref_clk;
    logic          rst_b = 1'b0;
    logic          hsel = 1'b0, hwrite = 1'b0, hready;
    logic          capturePin = 1'b0, extClockPin = 1'b0;
    logic          fastTickIn = 1'b0, subTickIn = 1'b0;
    logic          hreadyout, hresp, timerOut, timerOutEn, matchA, matchP;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, lfsr = 32'hCCF5;
    logic [1:0]    htrans = 2'h0;
    logic [2:0]    hsize = 3'h0;
    ptm_count_type captureValue;
    int            bad_count = 0, cmp_count = 0, seenA = 0, seenP = 0, expA = 0, expP = 0;
    int            mCnt, mCmp, mPer, mPin, mCap, fA, fP, mRun;
    int            mMode, mAct, mOls, mInv, mCaps, mClr;

    assign hready = hreadyout;

    ptm_timer dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capturePin(capturePin),
        .extClockPin(extClockPin), .fastTickIn(fastTickIn), .subTickIn(subTickIn),
        .timerOut(timerOut), .timerOutEn(timerOutEn), .matchA(matchA), .matchP(matchP),
        .captureValue(captureValue));

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // unused fast tick source still gets random traffic to catch leakage
    always @(posedge ref_clk) begin
        lfsr <= nextRand(lfsr);
        fastTickIn <= lfsr[0];
        seenA <= seenA + (matchA === 1'b1);
        seenP <= seenP + (matchP === 1'b1);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(60000 * 50);
        bad_count++;
        summarize();
    end

    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
    endtask

    task automatic busOp(input logic wrOp, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `PTM_HTRANS_NONSEQ;
        hwrite <= wrOp;
        hsize <= `PTM_HSIZE_WORD;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        chk(hresp, 0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        busOp(1'b1, a, d, x);
    endtask

    task automatic rdChk(input logic [7:0] a, input int exp);
        logic [31:0] x;
        busOp(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask

    function automatic int expPin();
        int act;
        if (mMode != 2) return mPin ^ mInv;
        act = (mAct == 2) ? (mCnt < mCmp || mCmp >= mPer && mPer != 0)
                          : (mAct == 3) ? mRun : (mAct == 1);
        return (act ? mOls : 1 - mOls) ^ mInv;
    endfunction

    task automatic checkOut;
        chk(timerOutEn, (mMode == 0 || mMode == 2));
        if (mMode == 0 || mMode == 2) chk(timerOut, expPin());
    endtask

    // off first: mode changes while running are unpredictable
    task automatic cfg(input int mode, act, ols, inv, caps, clr);
        wr(`PTM_OFF_CTRL0, 32'h40);
        mRun = 0;
        mMode = mode;
        mAct = act;
        mOls = ols;
        mInv = inv;
        mCaps = caps;
        mClr = clr;
        wr(`PTM_OFF_CTRL1, mode << 6 | act << 4 | ols << 3 | inv << 2 | caps << 1 | clr);
    endtask

    task automatic setCP(input int c, input int p);
        wr(`PTM_OFF_CMPL, c % 256);
        wr(`PTM_OFF_CMPH, c / 256);
        wr(`PTM_OFF_PERL, p % 256);
        wr(`PTM_OFF_PERH, p / 256);
        mCmp = c;
        mPer = p;
        mCap = c;
    endtask

    task automatic turnOn;
        wr(`PTM_OFF_CTRL0, 32'h48);
        mRun = 1;
        mCnt = 0;
        mPin = mOls;
        repeat (3) @(posedge ref_clk);
        checkOut();
    endtask

    task automatic tick(input int n);
        int a, p;
        repeat (n) begin
            @(posedge ref_clk);
            subTickIn <= 1'b1;
            @(posedge ref_clk);
            subTickIn <= 1'b0;
            if (mRun) begin
                a = (mCnt == mCmp && (mCmp != 0 || mMode == 2) && mMode != 1);
                p = (mCnt == mPer && mPer != 0 && !(mMode == 2 && mAct == 3)
                     && (mClr == 0 || mMode != 0 && mMode != 3));
                fA |= a;
                fP |= p;
                expA += a;
                expP += p;
                if (mMode == 0 && a && mAct != 0) mPin = (mAct == 3) ? 1 - mPin : mAct - 1;
                mCnt = ((mClr && (mMode == 0 || mMode == 3)) ? a : p) ? 0 : (mCnt + 1) % 1024;
                if (mMode == 2 && mAct == 3 && a) mRun = 0;
            end
            repeat (3) @(posedge ref_clk);
            checkOut();
        end
    endtask

    task automatic chkCnt;
        rdChk(`PTM_OFF_CNTL, mCnt % 256);
        rdChk(`PTM_OFF_CNTH, mCnt / 256);
    endtask

    task automatic chkFlags;
        rdChk(`PTM_OFF_FLAGS, fA | (fP << 1));
        wr(`PTM_OFF_FLAGS, 32'h3);
        fA = 0;
        fP = 0;
        chk(seenA, expA);
        chk(seenP, expP);
    endtask

    // rising then falling edge; only the selected source may capture
    task automatic pulse(input int which);
        repeat (2) begin
            @(posedge ref_clk);
            if (which) extClockPin <= ~extClockPin;
            else capturePin <= ~capturePin;
            repeat (3) @(posedge ref_clk);
        end
        if (which == mCaps) mCap = mCnt;
        chk(captureValue, mCap);
    endtask

    initial begin
        int v;
        fA = 0;
        fP = 0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        wr(8'h24, 32'hFFFF_FFFF);
        for (int a = 0; a <= 36; a += 4) rdChk(a[7:0], 0);
        for (int i = 4; i < 8; i++) begin
            v = lfsr;
            wr(8'(i * 4), v);
            rdChk(8'(i * 4), v & (i[0] ? 3 : 255));
        end
        wr(`PTM_OFF_CNTL, 32'hFF);
        cfg(0, 0, 0, 0, 0, 0);
        setCP(0, 0);
        turnOn();
        tick(5);
        chkCnt();
        wr(`PTM_OFF_CTRL0, 32'hC8);
        mRun = 0;
        tick(3);
        chkCnt();
        wr(`PTM_OFF_CTRL0, 32'h48);
        mRun = 1;
        tick(2);
        wr(`PTM_OFF_CTRL0, 32'h40);
        mRun = 0;
        tick(2);
        chkCnt();
        turnOn();
        chkCnt();
        for (int c = 0; c < 2; c++) begin
            cfg(0, 0, 0, 0, 0, c);
            turnOn();
            tick(1030);
            chkCnt();
            chkFlags();
        end
        for (int k = 0; k < 16; k++) begin
            cfg(0, k % 4, k[2], k[3], 0, k[2] ^ k[3]);
            setCP(2, (k[2] ^ k[3]) ? 1 : 5);
            turnOn();
            tick(13);
            chkFlags();
        end
        cfg(3, 3, 1, 1, 0, 0);
        turnOn();
        tick(13);
        chkFlags();
        for (int k = 0; k < 12; k++) begin
            cfg(2, k < 8 ? 2 : k % 2, k[1], k[2], 0, k[0]);
            setCP(k[0] ? 6 + 2 * k[1] : 3, 6);
            turnOn();
            tick(15);
            chkFlags();
        end
        cfg(2, 3, 1, 0, 0, 0);
        setCP(3, 6);
        turnOn();
        tick(6);
        chkCnt();
        chkFlags();
        cfg(1, 0, 0, 0, 0, 0);
        setCP(0, 0);
        turnOn();
        tick(4);
        pulse(1);
        pulse(0);
        cfg(1, 2, 0, 0, 1, 0);
        turnOn();
        tick(6);
        pulse(0);
        pulse(1);
        summarize();
    end
endmodule
